// ==== verilog/err_chk_cfg.svh ====
`ifndef ERR_CHK_CFG_SVH
`define ERR_CHK_CFG_SVH
// register offsets
`define OFS_TO_CTL      8'h00
`define OFS_TO_STS      8'h04
`define OFS_TO_CNT      8'h08
`define OFS_TO_RPT      8'h0C
`define OFS_PE_STS      8'h10
`define OFS_PE_CNT      8'h14
`define OFS_PE_RPT      8'h18
`define OFS_PE_CTL      8'h1C
// field positions
`define PE_CTL_DIS_BIT  0
`define PE_CTL_INJ_BIT  1
`define PE_CTL_LEN_LSB  16
// reset values
`define TO_RPT_RST      8'h82
`define PE_RPT_RST      2'h2
// timing and link crc
`define TO_LIMIT_S      64
`define CLK_HZ          125_000_000
`define CRC_SEED        32'hFFFF_FFFF
`define CRC_POLY        32'h04C1_1DB7
`endif

// ==== verilog/err_chk_pkg.sv ====
package err_chk_pkg;
    typedef enum logic [1:0] { RPT_NONE, RPT_COR, RPT_NONFATAL, RPT_FATAL } rpt_t;
    typedef struct packed {
        logic        to_dis;
        logic [3:0]  to_sts;
        logic [31:0] to_cnt;
        logic [7:0]  to_rpt;
        logic        pe_sts;
        logic [7:0]  pe_cnt;
        logic [1:0]  pe_rpt;
        logic        pe_dis;
        logic        pe_inj;
        logic [9:0]  pe_len;
        logic [31:0] rdata;
        logic [26:0] tick;
        logic [7:0]  sec;
        logic        inj_hit;
        logic [31:0] ing_data;
        logic        ing_par;
        logic        ing_valid;
        logic        ing_sop;
        logic        ing_eop;
        logic        ing_retry;
        logic        head_drop;
        logic        bcast_abort;
        logic [31:0] crc;
        logic        eg_err;
        logic [31:0] tx_data;
        logic        tx_valid;
        logic        tx_eop;
        logic [31:0] tx_crc;
        logic        tx_crc_valid;
        logic        tx_edb;
        logic        cons_err;
        logic        cons_discard;
        logic [4:0]  pend;
        logic [9:0]  pend_kind;
        logic        msg_valid;
        logic [1:0]  msg_kind;
    } state_t;
endpackage

// ==== verilog/err_chk.sv ====
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "err_chk_cfg.svh"
// Summary of operation
// - drop queue-head TLPs older than 64 seconds
// - age drop on after reset, bit disables
// - drop sets per-type time-out status bit
// - per-type saturating drop counters, clear-on-read
// - per-type reporting field selects message kind
// - messages masked by command/device enables
// - message only on status zero-to-one edge
// - no repeat until software clears status
// - reset: posted/inserted nonfatal, others silent
// - time-out aborts broadcast TLP processing
// - ingress checks link CRC, computes dword parity
// - link CRC error requests partner retransmission
// - content change updates parity incrementally
// - egress checks parity while computing link CRC
// - egress parity error inverts CRC, ends EDB
// - egress error sets status, bumps saturating counter
// - memory parity flows into end-to-end check
// - parity reporting field, message on rising status
// - check-disable bit stops checking, never generation
// - inject inverts parity on matching-length TLPs
// - reset: checking on, errors reported nonfatal
// - generated TLPs get parity; bad consumed dropped
module err_chk #(
    parameter int unsigned SEC_CYCLES = `CLK_HZ
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        system_error_enable,
    input  wire logic        correctable_report_enable,
    input  wire logic        nonfatal_report_enable,
    input  wire logic        fatal_report_enable,
    input  wire logic        unsupported_request_report_enable,
    input  wire logic        in_valid,
    input  wire logic        in_sop,
    input  wire logic        in_eop,
    input  wire logic [31:0] in_data,
    input  wire logic [9:0]  in_len,
    input  wire logic        in_crc_ok,
    output logic      [31:0] ing_data,
    output logic             ing_par,
    output logic             ing_valid,
    output logic             ing_sop,
    output logic             ing_eop,
    output logic             ing_retry,
    output logic      [7:0]  arrival_stamp,
    input  wire logic        head_valid,
    input  wire logic [7:0]  head_stamp,
    input  wire logic [1:0]  head_type,
    input  wire logic        head_bcast,
    output logic             head_drop,
    output logic             bcast_abort,
    input  wire logic        eg_valid,
    input  wire logic        eg_sop,
    input  wire logic        eg_eop,
    input  wire logic [31:0] eg_data,
    input  wire logic        eg_par,
    input  wire logic        eg_rewrite,
    input  wire logic [31:0] eg_new_data,
    output logic      [31:0] tx_data,
    output logic             tx_valid,
    output logic             tx_eop,
    output logic      [31:0] tx_crc,
    output logic             tx_crc_valid,
    output logic             tx_edb,
    input  wire logic        cons_valid,
    input  wire logic        cons_eop,
    input  wire logic [31:0] cons_data,
    input  wire logic        cons_par,
    output logic             cons_discard,
    output logic             msg_valid,
    output logic      [1:0]  msg_kind
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? `CRC_POLY : 32'h0000_0000);
        end
        return r;
    endfunction

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        return (v == 8'hFF) ? v : v + 8'h01;
    endfunction

    // true when a dword disagrees with its even parity bit
    function automatic logic par_bad(input logic [31:0] d, input logic p);
        return p != ^d;
    endfunction

    // message allowed for this kind under command/device enables
    function automatic logic rpt_ok(input logic [1:0] k, input logic serr, input logic cor,
                                    input logic nf, input logic fat, input logic ur);
        logic r;
        unique case (err_chk_pkg::rpt_t'(k))
            err_chk_pkg::RPT_NONE:     r = 1'b0;
            err_chk_pkg::RPT_COR:      r = cor | ur;
            err_chk_pkg::RPT_NONFATAL: r = nf | serr;
            err_chk_pkg::RPT_FATAL:    r = fat | serr;
        endcase
        return r;
    endfunction

    localparam int unsigned TO_LIMIT = `TO_LIMIT_S;

    err_chk_pkg::state_t s_r;
    err_chk_pkg::state_t s_nxt;

    logic [3:0]  to_set;
    logic        pe_set;
    logic [4:0]  rise;
    logic [9:0]  kinds;
    logic [31:0] eg_d;
    logic        eg_p;
    logic        eg_bad;
    logic [31:0] crc_c;
    logic [7:0]  age;
    logic [2:0]  pick;
    logic        rd_cnt_to;
    logic        rd_cnt_pe;

    always_comb begin
        s_nxt = s_r;

        // ------------------------------------------------------------
        // core time base and age check
        // ------------------------------------------------------------
        // one-second tick of the core clock
        if (s_r.tick == 27'(SEC_CYCLES - 1)) begin
            s_nxt.tick = 27'h000_0000;
            s_nxt.sec  = s_r.sec + 8'h01;
        end else begin
            s_nxt.tick = s_r.tick + 27'h000_0001;
        end

        // stamps wrap, so the age is taken modulo 256 seconds
        age    = s_r.sec - head_stamp;
        to_set = 4'h0;
        s_nxt.head_drop   = 1'b0;
        s_nxt.bcast_abort = 1'b0;

        // no second drop while the queue pops the head
        if (head_valid && !s_r.to_dis && age > 8'(TO_LIMIT) && !s_r.head_drop) begin
            s_nxt.head_drop   = 1'b1;
            s_nxt.bcast_abort = head_bcast;
            to_set[head_type] = 1'b1;
        end

        // ------------------------------------------------------------
        // ingress: parity generation, injection, link CRC result
        // ------------------------------------------------------------
        s_nxt.ing_valid = in_valid;
        s_nxt.ing_sop   = in_valid & in_sop;
        s_nxt.ing_eop   = in_valid & in_eop;
        // bad link crc: ask the partner to resend
        s_nxt.ing_retry = in_valid & in_eop & ~in_crc_ok;
        s_nxt.ing_data  = in_data;

        // injection decision latched at the first dword of each TLP
        if (in_valid && in_sop) begin
            s_nxt.inj_hit = s_r.pe_inj && (in_len == s_r.pe_len);
        end
        // generation always runs; only injection alters it
        s_nxt.ing_par = ^in_data ^ ((in_valid && in_sop) ? s_nxt.inj_hit : s_r.inj_hit);

        // ------------------------------------------------------------
        // egress: incremental update, parity check, link CRC
        // ------------------------------------------------------------
        eg_d   = eg_rewrite ? eg_new_data : eg_data;
        eg_p   = eg_rewrite ? (eg_par ^ ^eg_data ^ ^eg_new_data) : eg_par;
        eg_bad = eg_valid && !s_r.pe_dis && par_bad(eg_d, eg_p);
        crc_c  = crc_step(eg_sop ? `CRC_SEED : s_r.crc, eg_d);

        s_nxt.tx_valid     = eg_valid;
        s_nxt.tx_eop       = eg_valid & eg_eop;
        s_nxt.tx_data      = eg_d;
        s_nxt.tx_crc_valid = 1'b0;
        s_nxt.tx_edb       = 1'b0;

        pe_set = 1'b0;
        if (eg_valid) begin
            s_nxt.crc    = crc_c;
            s_nxt.eg_err = (eg_sop ? 1'b0 : s_r.eg_err) | eg_bad;
            if (eg_eop) begin
                // bad TLP keeps the raw remainder, the inverse of the normal crc
                s_nxt.tx_crc_valid = 1'b1;
                s_nxt.tx_edb       = s_nxt.eg_err;
                s_nxt.tx_crc       = s_nxt.eg_err ? crc_c : ~crc_c;
                pe_set             = s_nxt.eg_err;
            end
        end

        // ------------------------------------------------------------
        // consumed TLPs
        // ------------------------------------------------------------
        s_nxt.cons_discard = 1'b0;
        // consumed TLP errors join the end-to-end parity count
        if (cons_valid) begin
            s_nxt.cons_err = s_r.cons_err | (!s_r.pe_dis && par_bad(cons_data, cons_par));
            if (cons_eop) begin
                s_nxt.cons_discard = s_nxt.cons_err;
                pe_set             = pe_set | s_nxt.cons_err;
                s_nxt.cons_err     = 1'b0;
            end
        end

        // ------------------------------------------------------------
        // register writes; hardware set wins over clear
        // ------------------------------------------------------------
        rd_cnt_to = reg_rd && reg_addr == `OFS_TO_CNT;
        rd_cnt_pe = reg_rd && reg_addr == `OFS_PE_CNT;

        if (reg_wr) begin
            unique case (reg_addr)
                `OFS_TO_CTL: s_nxt.to_dis = reg_wdata[0];
                `OFS_TO_STS: s_nxt.to_sts = s_r.to_sts & ~reg_wdata[3:0];
                `OFS_TO_RPT: s_nxt.to_rpt = reg_wdata[7:0];
                `OFS_PE_STS: s_nxt.pe_sts = s_r.pe_sts & ~reg_wdata[0];
                `OFS_PE_RPT: s_nxt.pe_rpt = reg_wdata[1:0];
                `OFS_PE_CTL: begin
                    s_nxt.pe_dis = reg_wdata[`PE_CTL_DIS_BIT];
                    s_nxt.pe_inj = reg_wdata[`PE_CTL_INJ_BIT];
                    s_nxt.pe_len = reg_wdata[`PE_CTL_LEN_LSB +: 10];
                end
                default: ;
            endcase
        end

        // clear on read; an event in the same cycle counts from zero
        if (rd_cnt_to) begin
            s_nxt.to_cnt = 32'h0000_0000;
        end
        if (rd_cnt_pe) begin
            s_nxt.pe_cnt = 8'h00;
        end

        for (int t = 0; t < 4; t++) begin
            if (to_set[t]) begin
                s_nxt.to_sts[t]        = 1'b1;
                s_nxt.to_cnt[t*8 +: 8] = sat_inc(rd_cnt_to ? 8'h00 : s_r.to_cnt[t*8 +: 8]);
            end
        end

        if (pe_set) begin
            s_nxt.pe_sts = 1'b1;
            s_nxt.pe_cnt = sat_inc(rd_cnt_pe ? 8'h00 : s_r.pe_cnt);
        end

        // ------------------------------------------------------------
        // register reads
        // ------------------------------------------------------------
        // read data stands one cycle, zero otherwise
        s_nxt.rdata = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                `OFS_TO_CTL: s_nxt.rdata = {31'h0000_0000, s_r.to_dis};
                `OFS_TO_STS: s_nxt.rdata = {28'h000_0000, s_r.to_sts};
                `OFS_TO_CNT: s_nxt.rdata = s_r.to_cnt;
                `OFS_TO_RPT: s_nxt.rdata = {24'h00_0000, s_r.to_rpt};
                `OFS_PE_STS: s_nxt.rdata = {31'h0000_0000, s_r.pe_sts};
                `OFS_PE_CNT: s_nxt.rdata = {24'h00_0000, s_r.pe_cnt};
                `OFS_PE_RPT: s_nxt.rdata = {30'h0000_0000, s_r.pe_rpt};
                `OFS_PE_CTL: s_nxt.rdata = {6'h00, s_r.pe_len, 14'h0000, s_r.pe_inj, s_r.pe_dis};
                default:     s_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // ------------------------------------------------------------
        // error messages: one per status rising edge
        // ------------------------------------------------------------
        // lowest index first; issue before new arrivals so a fresh rise is kept
        s_nxt.msg_valid = 1'b0;
        pick = 3'h0;
        for (int i = 4; i >= 0; i--) begin
            if (s_r.pend[i]) begin
                pick = 3'(i);
            end
        end
        if (s_r.pend != 5'h00) begin
            s_nxt.msg_valid  = 1'b1;
            s_nxt.msg_kind   = s_r.pend_kind[pick*2 +: 2];
            s_nxt.pend[pick] = 1'b0;
        end

        rise  = {s_nxt.pe_sts & ~s_r.pe_sts, s_nxt.to_sts & ~s_r.to_sts};
        kinds = {s_r.pe_rpt, s_r.to_rpt};

        for (int i = 0; i < 5; i++) begin
            if (rise[i] && rpt_ok(kinds[i*2 +: 2], system_error_enable, correctable_report_enable,
                                  nonfatal_report_enable, fatal_report_enable,
                                  unsupported_request_report_enable)) begin
                s_nxt.pend[i]           = 1'b1;
                s_nxt.pend_kind[i*2 +: 2] = kinds[i*2 +: 2];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            // report fields start at their power-on policy
            s_r        <= '0;
            s_r.to_rpt <= `TO_RPT_RST;
            s_r.pe_rpt <= `PE_RPT_RST;
            s_r.crc    <= `CRC_SEED;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata     = s_r.rdata;
    assign ing_data      = s_r.ing_data;
    assign ing_par       = s_r.ing_par;
    assign ing_valid     = s_r.ing_valid;
    assign ing_sop       = s_r.ing_sop;
    assign ing_eop       = s_r.ing_eop;
    assign ing_retry     = s_r.ing_retry;
    assign arrival_stamp = s_r.sec;
    assign head_drop     = s_r.head_drop;
    assign bcast_abort   = s_r.bcast_abort;
    assign tx_data       = s_r.tx_data;
    assign tx_valid      = s_r.tx_valid;
    assign tx_eop        = s_r.tx_eop;
    assign tx_crc        = s_r.tx_crc;
    assign tx_crc_valid  = s_r.tx_crc_valid;
    assign tx_edb        = s_r.tx_edb;
    assign cons_discard  = s_r.cons_discard;
    assign msg_valid     = s_r.msg_valid;
    assign msg_kind      = s_r.msg_kind;

endmodule

// ==== sim/err_chk_checker.sv ====
`timescale 1ns/1ps
module err_chk_checker (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        in_valid,
    input wire logic        in_eop,
    input wire logic        in_crc_ok,
    input wire logic [31:0] in_data,
    input wire logic [31:0] ing_data,
    input wire logic        ing_valid,
    input wire logic        ing_retry,
    input wire logic        head_bcast,
    input wire logic        head_drop,
    input wire logic        bcast_abort,
    input wire logic        eg_valid,
    input wire logic        eg_eop,
    input wire logic        tx_valid,
    input wire logic        tx_eop,
    input wire logic        tx_crc_valid,
    input wire logic        tx_edb,
    input wire logic        cons_valid,
    input wire logic        cons_eop,
    input wire logic        cons_discard,
    input wire logic        msg_valid,
    input wire logic [1:0]  msg_kind
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside read slot");
    crc_retry_a: assert property (in_valid && in_eop && !in_crc_ok |=> ing_retry)
        else $error("no retransmit request on bad crc");
    ing_pass_a: assert property (in_valid |=> ing_valid && ing_data == $past(in_data))
        else $error("ingress beat not forwarded");
    abort_drop_a: assert property (bcast_abort |-> head_drop && $past(head_bcast))
        else $error("abort without broadcast drop");
    drop_once_a: assert property (head_drop |=> !head_drop)
        else $error("drop repeated");
    crc_eop_a: assert property (tx_crc_valid |-> tx_eop && tx_valid)
        else $error("crc not on last beat");
    edb_crc_a: assert property (tx_edb |-> tx_crc_valid)
        else $error("edb without crc");
    eg_tail_a: assert property (eg_valid && eg_eop |=> tx_crc_valid)
        else $error("egress crc late");
    cons_disc_a: assert property (cons_discard |-> $past(cons_eop) && $past(cons_valid))
        else $error("discard without consumed tail");
    msg_kind_a: assert property (msg_valid |-> msg_kind != 2'h0)
        else $error("message with no kind");
    cover property (head_drop && bcast_abort);
    cover property (tx_edb);
    cover property (msg_valid && msg_kind == 2'h2);
endmodule
bind err_chk err_chk_checker chk_inst (.*);

// ==== sim/link_rx_model.sv ====
`timescale 1ns/1ps
`include "err_chk_cfg.svh"
module link_rx_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [31:0] tx_data,
    input  wire logic        tx_valid,
    input  wire logic [31:0] tx_crc,
    input  wire logic        tx_crc_valid,
    input  wire logic        tx_edb,
    output int               good_cnt,
    output int               null_cnt,
    output int               bad_cnt
);
    logic [31:0] run_r;
    logic [31:0] nc;
    function automatic logic [31:0] upd(input logic [31:0] c, input logic [31:0] d);
        for (int i = 31; i >= 0; i--) c = (c << 1) ^ ((c[31] ^ d[i]) ? `CRC_POLY : 32'h0000_0000);
        return c;
    endfunction
    // receiver keeps good packets, drops nullified ones
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_r = `CRC_SEED;
            good_cnt = 0;
            null_cnt = 0;
            bad_cnt = 0;
        end else if (tx_valid) begin
            nc = upd(run_r, tx_data);
            run_r = nc;
            if (tx_crc_valid) begin
                if (tx_edb && tx_crc === nc) null_cnt++;
                else if (!tx_edb && tx_crc === ~nc) good_cnt++;
                else bad_cnt++;
                run_r = `CRC_SEED;
            end
        end
    end
endmodule

// ==== sim/switch_tlp_timeout_parity_errors_tb.sv ====
`timescale 1ns/1ps
`include "err_chk_cfg.svh"
module switch_tlp_timeout_parity_errors_tb;
    logic ref_clk, rst, reg_wr, reg_rd, in_valid, in_sop, in_eop, in_crc_ok, head_valid, head_bcast;
    logic eg_valid, eg_sop, eg_eop, eg_par, eg_rewrite, cons_valid, cons_eop, cons_par;
    logic system_error_enable, correctable_report_enable, nonfatal_report_enable;
    logic fatal_report_enable, unsupported_request_report_enable;
    logic ing_par, ing_valid, ing_sop, ing_eop, ing_retry, head_drop, bcast_abort;
    logic tx_valid, tx_eop, tx_crc_valid, tx_edb, cons_discard, msg_valid;
    logic [7:0]  reg_addr, head_stamp, arrival_stamp;
    logic [9:0]  in_len;
    logic [1:0]  head_type, msg_kind, msg_k;
    logic [31:0] reg_wdata, reg_rdata, in_data, eg_data, eg_new_data, tx_data, tx_crc, cons_data, ing_data;
    int          good_cnt, null_cnt, bad_cnt, good_exp, null_exp, msg_n, m0, retry_n, retry_exp, cyc;
    int          err_total, check_count;
    logic        inj_exp, ok, par_off;
    err_chk #(.SEC_CYCLES(1000)) err_chk_inst (.*);
    link_rx_model link_rx_model_inst (.*);
    initial begin
        ref_clk = 0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    // ----------------------------------------
    // bus and stream drivers
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge ref_clk) reg_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk) reg_rd <= 0;
        #1 chk(reg_rdata, e, "register read");
    endtask
    task automatic ing_pkt(input logic [9:0] len, input logic good, input logic inv);
        inj_exp = inv;
        @(posedge ref_clk) {in_valid, in_sop, in_len, in_data} <= {2'b11, len, $urandom};
        @(posedge ref_clk) {in_sop, in_eop, in_crc_ok, in_data} <= {2'b01, good, $urandom};
        @(posedge ref_clk) {in_valid, in_eop} <= 2'b00;
        @(posedge ref_clk);
    endtask
    task automatic eg_pkt(input logic bad, input logic rw);
        logic [31:0] d0, d1;
        d0 = $urandom;
        d1 = $urandom;
        @(posedge ref_clk) {eg_valid, eg_sop, eg_data, eg_par} <= {2'b11, d0, ^d0 ^ bad};
        @(posedge ref_clk) {eg_sop, eg_eop, eg_data, eg_par, eg_rewrite} <= {2'b01, d1, ^d1, rw};
        eg_new_data <= $urandom;
        @(posedge ref_clk) {eg_valid, eg_eop, eg_rewrite} <= 3'b000;
        #1 chk(tx_edb, bad & ~par_off, "edb flag");
        if (bad & ~par_off) null_exp++;
        else good_exp++;
    endtask
    task automatic head_try(input logic [1:0] t, input logic bc, input logic [7:0] age, input logic e);
        // start just after a seconds step so the age cannot slip
        @(arrival_stamp);
        @(posedge ref_clk) {head_valid, head_type, head_bcast, head_stamp} <= {1'b1, t, bc, arrival_stamp - age};
        @(posedge ref_clk) head_valid <= 0;
        #1 chk(head_drop, e, "drop");
        chk(bcast_abort, e & bc, "abort");
    endtask
    task automatic cons_pkt(input logic bad);
        @(posedge ref_clk) {cons_valid, cons_data, cons_par} <= {1'b1, 32'h0000_0001, ~bad};
        @(posedge ref_clk) {cons_eop, cons_data, cons_par} <= {1'b1, 32'h0000_0003, 1'b0};
        @(posedge ref_clk) {cons_valid, cons_eop} <= 2'b00;
        #1 chk(cons_discard, bad, "consumed discard");
    endtask
    // sample settled outputs mid-cycle
    always @(negedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            stop_test;
        end
        if (msg_valid === 1'b1) begin
            msg_n++;
            msg_k = msg_kind;
        end
        if (ing_retry === 1'b1) retry_n++;
        if (ing_valid === 1'b1) chk(ing_par, ^ing_data ^ inj_exp, "ingress parity");
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, in_valid, in_sop, in_eop, in_crc_ok, in_len, in_data} = '0;
        {head_valid, head_bcast, head_type, head_stamp, eg_valid, eg_sop, eg_eop, eg_par} = '0;
        {eg_rewrite, eg_data, eg_new_data, cons_valid, cons_eop, cons_par, cons_data} = '0;
        {system_error_enable, correctable_report_enable, fatal_report_enable} = '0;
        unsupported_request_report_enable = 0;
        nonfatal_report_enable = 1;
        {inj_exp, par_off} = 2'b00;
        rst = 1;
        ok = $urandom(13275);
        repeat (6) @(posedge ref_clk);
        rst <= 0;
        rd(`OFS_TO_RPT, 32'h0000_0082);
        rd(`OFS_PE_RPT, 32'h0000_0002);
        rd(`OFS_TO_CTL, 32'h0000_0000);
        rd(`OFS_PE_CTL, 32'h0000_0000);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0000_0000);
        repeat (12) begin
            ok = $urandom;
            retry_exp += !ok;
            ing_pkt(10'($urandom), ok, 0);
        end
        wr(`OFS_PE_CTL, 32'h0005_0002);
        ing_pkt(10'h005, 1, 1);
        ing_pkt(10'h006, 1, 0);
        wr(`OFS_PE_CTL, 32'h0000_0000);
        eg_pkt(0, 0);
        eg_pkt(0, 1);
        m0 = msg_n;
        eg_pkt(1, 0);
        repeat (2) @(posedge ref_clk);
        chk(msg_n, m0 + 1, "parity message");
        chk(msg_k, 2'h2, "parity message kind");
        eg_pkt(1, 0);
        repeat (2) @(posedge ref_clk);
        chk(msg_n, m0 + 1, "repeat message");
        rd(`OFS_PE_STS, 32'h0000_0001);
        rd(`OFS_PE_CNT, 32'h0000_0002);
        rd(`OFS_PE_CNT, 32'h0000_0000);
        wr(`OFS_PE_STS, 32'h0000_0001);
        nonfatal_report_enable <= 0;
        eg_pkt(1, 0);
        repeat (2) @(posedge ref_clk);
        chk(msg_n, m0 + 1, "masked message");
        wr(`OFS_PE_STS, 32'h0000_0001);
        {system_error_enable, correctable_report_enable, fatal_report_enable} <= 3'b111;
        eg_pkt(1, 0);
        repeat (2) @(posedge ref_clk);
        chk(msg_n, m0 + 2, "serr enabled message");
        for (int k = 0; k < 4; k++) begin
            wr(`OFS_PE_RPT, k);
            wr(`OFS_PE_STS, 32'h0000_0001);
            m0 = msg_n;
            eg_pkt(1, 0);
            repeat (2) @(posedge ref_clk);
            chk(msg_n, m0 + (k != 0), "report select count");
            if (k != 0) chk(msg_k, k, "report select kind");
        end
        rd(`OFS_PE_CNT, 32'h0000_0006);
        wr(`OFS_PE_CTL, 32'h0000_0001);
        par_off = 1;
        eg_pkt(1, 0);
        par_off = 0;
        wr(`OFS_PE_CTL, 32'h0000_0000);
        repeat (260) eg_pkt(1, 0);
        rd(`OFS_PE_CNT, 32'h0000_00FF);
        cons_pkt(0);
        cons_pkt(1);
        rd(`OFS_PE_CNT, 32'h0000_0001);
        m0 = msg_n;
        for (int t = 0; t < 4; t++) head_try(t, 0, 8'd65, 1);
        repeat (6) @(posedge ref_clk);
        chk(msg_n, m0 + 2, "drop messages");
        rd(`OFS_TO_STS, 32'h0000_000F);
        rd(`OFS_TO_CNT, 32'h0101_0101);
        rd(`OFS_TO_CNT, 32'h0000_0000);
        head_try(0, 0, 8'd64, 0);
        head_try(0, 1, 8'd65, 1);
        repeat (3) @(posedge ref_clk);
        chk(msg_n, m0 + 2, "held status message");
        wr(`OFS_TO_CTL, 32'h0000_0001);
        head_try(1, 0, 8'd65, 0);
        repeat (4) @(posedge ref_clk);
        chk(good_cnt, good_exp, "good packets");
        chk(null_cnt, null_exp, "nullified packets");
        chk(bad_cnt, 0, "corrupt packets");
        chk(retry_n, retry_exp, "retransmit requests");
        stop_test;
    end
endmodule
